// ---- design/ee_mem.sv ----
/*
 * Simple dual-port byte memory with a registered read port.
 * Assumes writer and reader share one clock; no reset on the array contents.
 */
`default_nettype none
module ee_mem #(
	parameter int DW = 8,
	parameter int AW = 8
) (
	// clock
	input  wire logic          clk_i,
	input  wire logic          ce_i,
	// write port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	// read port
	input  wire logic [AW-1:0] raddr_i,
	output var  logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem_reg [2**AW];

	// =====================================
	// storage and registered read
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem_reg[waddr_i] <= wdata_i;
			end
			rdata_o <= mem_reg[raddr_i];
		end
	end
endmodule
`default_nettype wire

// ---- design/ee_pkg.sv ----
/*
 * Shared constants and types of the serial nonvolatile memory slave engine.
 * Assumes a 200 MHz system clock and a two-wire bus whose clock is driven by the master.
 */
`default_nettype none
// How it works
// - byte write: address, byte address, data each acknowledged; byte address loads pointer
// - stop after a write starts programming; bus ignored until it ends
// - up to sixteen page bytes programmed in one cycle
// - each page data byte acknowledged, low page bits incremented, high bits kept
// - more than a page of bytes wraps in page, overwriting earlier bytes
// - stop commits all buffered page bytes in one programming cycle
// - no acknowledge to own write address while programming runs
// - write protect: addresses acknowledged, first data byte refused, nothing programmed
// - read starts like write with direction bit set; three read forms
// - counter holds last accessed address plus one
// - counter past top array address wraps to zero
// - current-address read: acknowledge address, send one byte, master nacks, stops
// - random read: dummy write of byte address, repeated start, read
// - sequential read: next byte per master acknowledge, ends on nack and stop
// - read increments use every address bit
// - slave address matches type code and select straps or high address bits
// - receiver acknowledges by pulling data low on the ninth clock
// - write cycle from stop to end at most 10 ms, bus disabled
package ee_pkg;
	// array geometry, 2 kbit density by default
	localparam int          ADDR_W_DEF   = 8;
	localparam int          PAGE_W_DEF   = 4;
	localparam int          BYTE_W       = 8;
	// slave address byte fields
	localparam int          DIR_BIT      = 0;
	localparam int          SEL_LSB      = 1;
	localparam int          TYPE_LSB     = 4;
	localparam int          SEL_W        = 3;
	localparam logic [3:0]  DEV_TYPE_DEF = 4'h5; // arbitrary value, set per product
	// bit counts inside one byte slot
	localparam logic [3:0]  CNT_LAST     = 4'h7;
	localparam logic [3:0]  CNT_BYTE     = 4'h8;
	localparam logic [3:0]  CNT_ACK      = 4'h9;
	// write cycle time
	localparam int          CLK_NS       = 5;
	localparam int          T_WR_MS      = 10;
	localparam int          WR_CYCLES    = T_WR_MS * 1000000 / CLK_NS;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_PROG} ee_state_t;
	typedef enum logic [1:0] {PH_DEV, PH_WORD, PH_DATA} ee_phase_t;
endpackage
`default_nettype wire

// ---- design/ee_rw_engine.sv ----
/*
 * Two-wire bus slave engine of a byte-organised nonvolatile memory with page buffer.
 * Assumes the master drives the bus clock, which clocks the bit sampler; the rest runs on mclk_i.
 */
`default_nettype none
module ee_rw_engine #(
	parameter int         ADDR_W    = ee_pkg::ADDR_W_DEF,
	parameter int         PAGE_W    = ee_pkg::PAGE_W_DEF,
	parameter int         WR_CYCLES = ee_pkg::WR_CYCLES,
	parameter logic [3:0] DEV_TYPE  = ee_pkg::DEV_TYPE_DEF
) (
	// system clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// two-wire bus
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic sda_o,
	output var  logic sda_oe_o,
	// straps and protect
	input  wire logic chip_select_strap_0_i,
	input  wire logic chip_select_strap_1_i,
	input  wire logic chip_select_strap_2_i,
	input  wire logic write_protect_i,
	// status
	output var  logic busy_o
);
	localparam int SEL_USED = (ADDR_W > 8) ? ADDR_W - 8 : 0;
	localparam int WTW      = $clog2(WR_CYCLES + 1);
	localparam int NPAGE    = 2 ** PAGE_W;

	// ==================================================
	// helpers
	// byte address plus high bits from the slave address, cut to the array size
	function automatic logic [ADDR_W-1:0] full_addr(input logic [2:0] sel, input logic [7:0] word);
		logic [10:0] t;
		t = {sel, word};
		return t[ADDR_W-1:0];
	endfunction

	// slave address match; select bits used as address bits are not compared
	function automatic logic dev_hit(input logic [7:0] b, input logic [2:0] straps);
		logic ok;
		ok = (b[ee_pkg::TYPE_LSB +: 4] == DEV_TYPE);
		for (int i = 0; i < ee_pkg::SEL_W; i++) begin
			if (i >= SEL_USED && b[ee_pkg::SEL_LSB + i] != straps[i]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// ==================================================
	// link domain: sample data on each rising bus clock
	logic lk_bit_reg, lk_bit_next;
	logic lk_tgl_reg, lk_tgl_next;

	// the toggle marks a new sample; the bit is held a full bus clock, so it is stable when read
	always_comb begin
		lk_bit_next = sda_i;
		lk_tgl_next = ~lk_tgl_reg;
	end

	always_ff @(posedge scl_i or posedge rst_i) begin
		if (rst_i) begin
			lk_bit_reg <= 1'b0;
			lk_tgl_reg <= 1'b0;
		end else begin
			lk_bit_reg <= lk_bit_next;
			lk_tgl_reg <= lk_tgl_next;
		end
	end

	// ==================================================
	// synchronisers: {toggle, protect, straps, scl, sda}
	logic [6:0] sy1_reg, sy1_next;
	logic [6:0] sy2_reg, sy2_next;
	logic [2:0] dl_reg, dl_next; // {toggle, scl, sda} one cycle later

	// stage one is read by stage two only
	always_comb begin
		sy1_reg_hold: begin
			sy1_next = sy1_reg;
			sy2_next = sy2_reg;
			dl_next  = dl_reg;
			if (ce_i) begin
				sy1_next = {lk_tgl_reg, write_protect_i, chip_select_strap_2_i,
				            chip_select_strap_1_i, chip_select_strap_0_i, scl_i, sda_i};
				sy2_next = sy1_reg;
				dl_next  = {sy2_reg[6], sy2_reg[1:0]};
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// bus idle with the toggle at the sampler's reset level, so no false sample follows reset
			sy1_reg <= 7'h03;
			sy2_reg <= 7'h03;
			dl_reg  <= 3'h3;
		end else begin
			sy1_reg <= sy1_next;
			sy2_reg <= sy2_next;
			dl_reg  <= dl_next;
		end
	end

	logic       scl_s, sda_s, wp_s, smp_ev, fall_ev, start_ev, stop_ev;
	logic [2:0] straps_s;

	// bus events in the system domain
	always_comb begin
		sda_s    = sy2_reg[0];
		scl_s    = sy2_reg[1];
		straps_s = sy2_reg[4:2];
		wp_s     = sy2_reg[5];
		smp_ev   = sy2_reg[6] ^ dl_reg[2];
		fall_ev  = dl_reg[1] & ~scl_s;
		start_ev = scl_s & dl_reg[1] & dl_reg[0] & ~sda_s;
		stop_ev  = scl_s & dl_reg[1] & ~dl_reg[0] & sda_s;
	end

	// ==================================================
	// protocol engine
	ee_pkg::ee_state_t  st_reg, st_next;
	ee_pkg::ee_phase_t  ph_reg, ph_next;
	logic [3:0]         cnt_reg, cnt_next;
	logic [7:0]         sh_reg, sh_next;
	logic [7:0]         tx_reg, tx_next;
	logic [2:0]         sel_reg, sel_next;
	logic               rd_reg, rd_next;
	logic               ackok_reg, ackok_next;
	logic [ADDR_W-1:0]  addr_reg, addr_next;
	logic [NPAGE-1:0]   vld_reg, vld_next;
	logic [WTW-1:0]     wt_reg, wt_next;
	logic [PAGE_W:0]    cm_reg, cm_next;
	logic               oe_reg, oe_next;
	logic               busy_reg, busy_next;
	logic [7:0]         rx_byte, buf_rd, mem_rd;
	logic               addr_hit, buf_we, mem_we;

	always_comb begin
		rx_byte  = {sh_reg[6:0], lk_bit_reg};
		addr_hit = dev_hit(rx_byte, straps_s);
	end

	// next state of the engine; the system clock enable freezes every register
	always_comb begin
		st_next    = st_reg;
		ph_next    = ph_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		tx_next    = tx_reg;
		sel_next   = sel_reg;
		rd_next    = rd_reg;
		ackok_next = ackok_reg;
		addr_next  = addr_reg;
		vld_next   = vld_reg;
		wt_next    = wt_reg;
		cm_next    = cm_reg;
		oe_next    = oe_reg;
		busy_next  = busy_reg;
		buf_we     = 1'b0;
		mem_we     = 1'b0;
		if (ce_i) begin
			if (st_reg == ee_pkg::ST_PROG) begin
				// bus is deaf while the array programs
				wt_next = wt_reg + 1'b1;
				if (cm_reg != '1) begin
					cm_next = cm_reg + 1'b1;
				end
				// whole page committed in one cycle, two clocks per slot
				mem_we = cm_reg[0] & vld_reg[cm_reg[PAGE_W:1]];
				if (wt_reg == WTW'(WR_CYCLES - 1)) begin
					// end of the write cycle; a poll is answered from here on
					st_next   = ee_pkg::ST_IDLE;
					busy_next = 1'b0;
					vld_next  = '0;
				end
			end else if (start_ev) begin
				// start in any state but programming restarts addressing and drops unfinished page data
				st_next  = ee_pkg::ST_RX;
				ph_next  = ee_pkg::PH_DEV;
				cnt_next = 4'h0;
				oe_next  = 1'b0;
				vld_next = '0;
			end else if (stop_ev) begin
				oe_next = 1'b0;
				// the clock pulse that leads into a stop is already counted as one bit of a new byte
				if (st_reg == ee_pkg::ST_RX && ph_reg == ee_pkg::PH_DATA && cnt_reg <= 4'h1 && |vld_reg) begin
					st_next   = ee_pkg::ST_PROG;
					busy_next = 1'b1;
					wt_next   = '0;
					cm_next   = '0;
				end else begin
					st_next  = ee_pkg::ST_IDLE; // mid-byte stop: nothing programmed
					vld_next = '0;
				end
			end else begin
				case (st_reg)
					ee_pkg::ST_RX: begin
						if (smp_ev) begin
							sh_next  = rx_byte;
							cnt_next = cnt_reg + 1'b1;
							if (cnt_reg == ee_pkg::CNT_LAST) begin
								st_next = ee_pkg::ST_ACK;
								case (ph_reg)
									ee_pkg::PH_DEV: begin
										// type code and straps must match
										if (!addr_hit) begin
											st_next = ee_pkg::ST_IDLE;
										end
										rd_next  = rx_byte[ee_pkg::DIR_BIT];
										sel_next = rx_byte[ee_pkg::SEL_LSB +: ee_pkg::SEL_W];
									end
									ee_pkg::PH_WORD: begin
										addr_next = full_addr(sel_reg, rx_byte);
									end
									default: begin
										if (wp_s) begin
											st_next = ee_pkg::ST_IDLE; // protected: refuse data
										end else begin
											// buffer byte, bump page offset only
											buf_we   = 1'b1;
											vld_next = vld_reg | (NPAGE'(1) << addr_reg[PAGE_W-1:0]);
											addr_next[PAGE_W-1:0] = addr_reg[PAGE_W-1:0] + 1'b1;
										end
									end
								endcase
							end
						end
					end
					ee_pkg::ST_ACK: begin
						if (smp_ev) begin
							cnt_next = ee_pkg::CNT_ACK;
						end
						if (fall_ev && cnt_reg == ee_pkg::CNT_BYTE) begin
							oe_next = 1'b1; // pull data low for the ninth clock
						end else if (fall_ev && cnt_reg == ee_pkg::CNT_ACK) begin
							cnt_next = 4'h0;
							oe_next  = 1'b0;
							if (ph_reg == ee_pkg::PH_DEV && rd_reg) begin
								// read from the current counter
								st_next   = ee_pkg::ST_TX;
								tx_next   = mem_rd;
								oe_next   = ~mem_rd[7];
								addr_next = addr_reg + 1'b1;
							end else begin
								st_next = ee_pkg::ST_RX;
								ph_next = (ph_reg == ee_pkg::PH_DEV) ? ee_pkg::PH_WORD : ee_pkg::PH_DATA;
							end
						end
					end
					ee_pkg::ST_TX: begin
						if (smp_ev) begin
							cnt_next = cnt_reg + 1'b1;
						end
						if (fall_ev) begin
							if (cnt_reg == ee_pkg::CNT_BYTE) begin
								oe_next    = 1'b0; // release for the master's answer
								st_next    = ee_pkg::ST_MACK;
								ackok_next = 1'b0;
							end else begin
								tx_next = {tx_reg[6:0], 1'b0};
								oe_next = ~tx_reg[6];
							end
						end
					end
					ee_pkg::ST_MACK: begin
						if (smp_ev) begin
							if (lk_bit_reg) begin
								st_next = ee_pkg::ST_IDLE; // nack ends the read
							end else begin
								ackok_next = 1'b1;
							end
						end
						if (fall_ev && ackok_reg) begin
							// master wants more: next byte over the whole array
							st_next    = ee_pkg::ST_TX;
							cnt_next   = 4'h0;
							ackok_next = 1'b0;
							tx_next    = mem_rd;
							oe_next    = ~mem_rd[7];
							addr_next  = addr_reg + 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg    <= ee_pkg::ST_IDLE;
			ph_reg    <= ee_pkg::PH_DEV;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			tx_reg    <= 8'h00;
			sel_reg   <= 3'h0;
			rd_reg    <= 1'b0;
			ackok_reg <= 1'b0;
			addr_reg  <= '0;
			vld_reg   <= '0;
			wt_reg    <= '0;
			cm_reg    <= '0;
			oe_reg    <= 1'b0;
			busy_reg  <= 1'b0;
		end else begin
			st_reg    <= st_next;
			ph_reg    <= ph_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			tx_reg    <= tx_next;
			sel_reg   <= sel_next;
			rd_reg    <= rd_next;
			ackok_reg <= ackok_next;
			addr_reg  <= addr_next;
			vld_reg   <= vld_next;
			wt_reg    <= wt_next;
			cm_reg    <= cm_next;
			oe_reg    <= oe_next;
			busy_reg  <= busy_next;
		end
	end

	// open-drain: only ever drive low
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	always_comb begin
		sda_oe_o = oe_reg;
		busy_o   = busy_reg;
	end

	// ==================================================
	// page buffer and array
	ee_mem #(.DW(8), .AW(PAGE_W)) u_page (
		.clk_i   (mclk_i),
		.ce_i    (ce_i),
		.we_i    (buf_we),
		.waddr_i (addr_reg[PAGE_W-1:0]),
		.wdata_i (rx_byte),
		.raddr_i (cm_reg[PAGE_W:1]),
		.rdata_o (buf_rd)
	);

	ee_mem #(.DW(8), .AW(ADDR_W)) u_array (
		.clk_i   (mclk_i),
		.ce_i    (ce_i),
		.we_i    (mem_we),
		.waddr_i ({addr_reg[ADDR_W-1:PAGE_W], cm_reg[PAGE_W:1]}),
		.wdata_i (buf_rd),
		.raddr_i (addr_reg),
		.rdata_o (mem_rd)
	);

	// ==================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_byte_end;
		ce_i && smp_ev && !start_ev && !stop_ev && st_reg == ee_pkg::ST_RX && cnt_reg == ee_pkg::CNT_LAST;
	endsequence
	sequence s_stop_wr;
		ce_i && stop_ev && st_reg == ee_pkg::ST_RX && ph_reg == ee_pkg::PH_DATA && cnt_reg <= 4'h1 && |vld_reg;
	endsequence

	property p_dev_miss;
		s_byte_end ##0 (ph_reg == ee_pkg::PH_DEV && !addr_hit) |=> st_reg == ee_pkg::ST_IDLE;
	endproperty
	a_dev_miss: assert property (p_dev_miss) else $error("foreign slave address accepted");

	property p_wp_nack;
		s_byte_end ##0 (ph_reg == ee_pkg::PH_DATA && wp_s) |=> st_reg == ee_pkg::ST_IDLE && vld_reg == $past(vld_reg);
	endproperty
	a_wp_nack: assert property (p_wp_nack) else $error("protected data byte taken");

	property p_page_inc;
		s_byte_end ##0 (ph_reg == ee_pkg::PH_DATA && !wp_s) |=>
			addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]) &&
			addr_reg[PAGE_W-1:0] == PAGE_W'($past(addr_reg[PAGE_W-1:0]) + 1'b1) ##1 st_reg == ee_pkg::ST_ACK;
	endproperty
	a_page_inc: assert property (p_page_inc) else $error("page offset step wrong");

	property p_word_load;
		s_byte_end ##0 ph_reg == ee_pkg::PH_WORD |=> addr_reg == full_addr(sel_reg, $past(rx_byte));
	endproperty
	a_word_load: assert property (p_word_load) else $error("byte address not loaded");

	property p_stop_prog;
		s_stop_wr |=> st_reg == ee_pkg::ST_PROG && busy_o && !sda_oe_o [*3];
	endproperty
	a_stop_prog: assert property (p_stop_prog) else $error("stop did not start programming");

	property p_prog_deaf;
		st_reg == ee_pkg::ST_PROG && start_ev |=> st_reg != ee_pkg::ST_RX && !sda_oe_o;
	endproperty
	a_prog_deaf: assert property (p_prog_deaf) else $error("bus answered while programming");

	property p_prog_len;
		busy_o |-> wt_reg < WTW'(WR_CYCLES);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("write cycle too long");

	property p_abort;
		ce_i && start_ev && st_reg != ee_pkg::ST_PROG |=> st_reg == ee_pkg::ST_RX && cnt_reg == 4'h0 && vld_reg == '0;
	endproperty
	a_abort: assert property (p_abort) else $error("start did not restart");

	property p_seq_inc;
		ce_i && fall_ev && !start_ev && !stop_ev && st_reg == ee_pkg::ST_MACK && ackok_reg |=>
			st_reg == ee_pkg::ST_TX && addr_reg == ADDR_W'($past(addr_reg) + 1'b1);
	endproperty
	a_seq_inc: assert property (p_seq_inc) else $error("sequential read counter wrong");

	property p_drive_low_scl;
		$rose(sda_oe_o) |-> !scl_s;
	endproperty
	a_drive_low_scl: assert property (p_drive_low_scl) else $error("data driven while clock high");
endmodule
`default_nettype wire

// ---- testbench/ee_tb_master.sv ----
/*
 * Two-wire bus master model driving the memory engine from its own 15 ns tick.
 * Assumes an open-drain data wire with pull-up; the device only ever pulls low.
 */
`default_nettype none
module ee_tb_master (
	// device data drive
	input  wire logic dev_sda_i,
	input  wire logic dev_oe_i,
	// resolved bus
	output var  logic scl_o,
	output var  logic sda_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic tick;
	logic sda_m;

	// ==========================================
	// link tick; scl is derived from it and idles high between frames
	initial begin
		tick = 1'b0;
		scl_o = 1'b1;
		sda_m = 1'b1;
		#1;
		forever #7.5 tick = ~tick;
	end

	// wired-and with pull-up, so a released line reads high
	always_comb sda_o = sda_m & ~(dev_oe_i & ~dev_sda_i);

	task automatic w(input int n);
		repeat (n) @(posedge tick);
	endtask

	// data moves a tick after scl falls so it is never mistaken for start or stop
	task automatic bit_x(input logic b, output logic r);
		w(1);
		sda_m = b;
		w(2);
		scl_o = 1'b1;
		w(3);
		r = sda_o;
		scl_o = 1'b0;
	endtask

	// also serves as repeated start and as a fresh poll
	task automatic start;
		w(1);
		sda_m = 1'b1;
		w(2);
		scl_o = 1'b1;
		w(3);
		sda_m = 1'b0;
		w(3);
		scl_o = 1'b0;
	endtask

	task automatic stop;
		w(1);
		sda_m = 1'b0;
		w(2);
		scl_o = 1'b1;
		w(3);
		sda_m = 1'b1;
		w(3);
	endtask

	// msb first, ninth bit released for the device
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = ~r;
	endtask

	// master acks to ask for more, withholds it on the last byte
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(~mack, r);
	endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
/*
 * Self-checking bench of the memory engine: writes, polls, reads, protect and abort.
 * Assumes the bus master model in ee_tb_master and a write cycle shortened to WR_CYC clocks.
 */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int         WR_CYC = 600;
	localparam logic [2:0] STRAP  = 3'h5;
	localparam logic [3:0] DTYPE  = ee_pkg::DEV_TYPE_DEF;

	logic       mclk_i;
	logic       rst_i;
	logic       ce;
	logic       wp;
	logic       scl;
	logic       sda;
	logic       sda_drv;
	logic       sda_oe;
	logic       busy;
	logic       ack;
	logic [7:0] d;
	logic [7:0] q[$];
	int         fail_count;
	int         n_checks;
	int         cyc;

	ee_rw_engine #(.WR_CYCLES(WR_CYC)) dut_u (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
		.sda_oe_o(sda_oe), .chip_select_strap_0_i(STRAP[0]), .chip_select_strap_1_i(STRAP[1]),
		.chip_select_strap_2_i(STRAP[2]), .write_protect_i(wp), .busy_o(busy));
	ee_tb_master m_u (.dev_sda_i(sda_drv), .dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

	// ==========================================
	// clock and hang guard
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic sel(input logic [2:0] s, input logic rw);
		m_u.start();
		m_u.wr_byte({DTYPE, s, rw}, ack);
	endtask

	// bounded poll so a stuck busy cannot hang the run
	task automatic poll;
		int n = 0;
		ack = 1'b0;
		while (ack !== 1'b1 && n < 20) begin
			sel(STRAP, 1'b0);
			n++;
		end
		m_u.stop();
		chk("poll ack", {7'h0, ack}, 8'h01);
		chk("busy end", {7'h0, busy}, 8'h00);
	endtask

	task automatic wr_page(input logic [7:0] a, input int n, input logic [7:0] base);
		sel(STRAP, 1'b0);
		chk("dev ack", {7'h0, ack}, 8'h01);
		m_u.wr_byte(a, ack);
		chk("addr ack", {7'h0, ack}, 8'h01);
		for (int i = 0; i < n; i++) begin
			m_u.wr_byte(base + 8'(i), ack);
			chk("data ack", {7'h0, ack}, 8'h01);
		end
		m_u.stop();
		chk("busy", {7'h0, busy}, 8'h01);
		sel(STRAP, 1'b0);
		chk("poll nack", {7'h0, ack}, 8'h00);
		poll();
	endtask

	// random read when rnd is set, else from the current pointer
	task automatic rd(input logic rnd, input logic [7:0] a, input logic [7:0] exp[$]);
		if (rnd) begin
			sel(STRAP, 1'b0);
			m_u.wr_byte(a, ack);
		end
		sel(STRAP, 1'b1);
		chk("read ack", {7'h0, ack}, 8'h01);
		foreach (exp[i]) begin
			m_u.rd_byte(i < exp.size() - 1, d);
			chk("read data", d, exp[i]);
		end
		m_u.stop();
	endtask

	// ==========================================
	// scenarios
	task automatic t_byte;
		wr_page(8'h10, 1, 8'h3c);
		rd(1'b1, 8'h10, '{8'h3c});
		$display("done t_byte");
	endtask

	// seventeen bytes: the last wraps onto offset 0 of the same page
	task automatic t_page;
		wr_page(8'h20, 17, 8'h40);
		rd(1'b0, 8'h00, '{8'h41});
		q = '{8'h50};
		for (int i = 1; i < 16; i++) begin
			q.push_back(8'h40 + 8'(i));
		end
		rd(1'b1, 8'h20, q);
		$display("done t_page");
	endtask

	task automatic t_wrap;
		wr_page(8'hf0, 16, 8'h80);
		wr_page(8'h00, 1, 8'h77);
		rd(1'b1, 8'hfe, '{8'h8e, 8'h8f, 8'h77});
		$display("done t_wrap");
	endtask

	task automatic t_wp;
		@(negedge mclk_i) wp = 1'b1;
		repeat (4) @(negedge mclk_i);
		sel(STRAP, 1'b0);
		chk("wp dev ack", {7'h0, ack}, 8'h01);
		m_u.wr_byte(8'h10, ack);
		chk("wp addr ack", {7'h0, ack}, 8'h01);
		m_u.wr_byte(8'h99, ack);
		chk("wp data nack", {7'h0, ack}, 8'h00);
		m_u.stop();
		chk("wp busy", {7'h0, busy}, 8'h00);
		@(negedge mclk_i) wp = 1'b0;
		rd(1'b1, 8'h10, '{8'h3c});
		$display("done t_wp");
	endtask

	task automatic t_addr;
		sel(STRAP ^ 3'h1, 1'b0);
		chk("strap nack", {7'h0, ack}, 8'h00);
		m_u.start();
		m_u.wr_byte({~DTYPE, STRAP, 1'b0}, ack);
		chk("type nack", {7'h0, ack}, 8'h00);
		m_u.stop();
		$display("done t_addr");
	endtask

	// one buffered byte, then a stop after four bits: the array must stay as it was
	task automatic t_abort;
		sel(STRAP, 1'b0);
		m_u.wr_byte(8'h10, ack);
		m_u.wr_byte(8'h55, ack);
		chk("abort data ack", {7'h0, ack}, 8'h01);
		repeat (4) m_u.bit_x(1'b0, d[0]);
		m_u.stop();
		chk("abort busy", {7'h0, busy}, 8'h00);
		rd(1'b1, 8'h10, '{8'h3c});
		$display("done t_abort");
	endtask

	// clock enable low freezes the write cycle, so busy outlasts its own count
	task automatic t_freeze;
		sel(STRAP, 1'b0);
		m_u.wr_byte(8'h30, ack);
		m_u.wr_byte(8'h5a, ack);
		m_u.stop();
		@(negedge mclk_i) ce = 1'b0;
		repeat (WR_CYC + 50) @(negedge mclk_i);
		chk("frozen busy", {7'h0, busy}, 8'h01);
		ce = 1'b1;
		poll();
		rd(1'b1, 8'h30, '{8'h5a});
		$display("done t_freeze");
	endtask

	// ==========================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		wp = 1'b0;
		ce = 1'b1;
		repeat (3) @(negedge mclk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		t_byte();
		t_page();
		t_wrap();
		t_wp();
		t_addr();
		t_abort();
		t_freeze();
		end_of_test();
	end
endmodule
`default_nettype wire
